/* tiny_cpu_datapath.v */
// datapath, flags and port registers of a 4-bit remote-control controller
`timescale 1ns/1ns
`include "tiny_cpu_consts.vh"
module tiny_cpu_datapath
#(
  parameter ROM_WORDS = `ROM_SIZE_DEFAULT
)
(
  input  wire        sys_clk,
  input  wire        reset,
  input  wire [9:0]  fetchAddr,
  output reg  [9:0]  romAddr,
  input  wire [9:0]  romData,
  output reg  [9:0]  fetchWord,
  output reg         restartReq,
  input  wire        tableFetch,
  input  wire [3:0]  aluOp,
  input  wire [3:0]  operand,
  input  wire        ramWrite,
  input  wire        ramPairWrite,
  input  wire [4:0]  ramAddr,
  input  wire [7:0]  ramPairData,
  output reg  [7:0]  ramReadPair,
  input  wire        callPush,
  input  wire [9:0]  returnAddr,
  output reg  [9:0]  stackTop,
  output reg  [3:0]  accumulator,
  output reg         carryBit,
  output reg         condBit,
  input  wire        condTest,
  input  wire        haltExec,
  input  wire        wakeCond,
  input  wire        standbyExit,
  input  wire        timerZero,
  output reg  [9:0]  tablePointer,
  input  wire        portWrite,
  input  wire [1:0]  portSel,
  input  wire [7:0]  portWriteData,
  output reg  [7:0]  portReadData,
  input  wire [7:0]  keyScanIn,
  output reg  [7:0]  keyScanOut,
  output reg         keyScanOe_n,
  input  wire [3:0]  keyInputPins,
  input  wire        senseInputA,
  input  wire        senseIndicatorIn,
  output reg         senseIndicatorOut,
  output reg         senseIndicatorOe_n,
  output reg  [7:0]  controlRegA,
  output reg  [7:0]  controlRegB
);

// ----------------------------------------
// pin synchronisers
// ----------------------------------------
reg  [7:0] scanMeta;
reg  [7:0] scanPin;
reg  [3:0] keyMeta;
reg  [3:0] keyPin;
reg  [1:0] senseMeta;
reg  [1:0] sensePin;

always @(posedge sys_clk or posedge reset)
begin
  if (reset)
  begin
    scanMeta  <= 8'h00;
    scanPin   <= 8'h00;
    keyMeta   <= 4'h0;
    keyPin    <= 4'h0;
    senseMeta <= 2'h0;
    sensePin  <= 2'h0;
  end
  else
  begin
    scanMeta  <= keyScanIn;
    scanPin   <= scanMeta;
    keyMeta   <= keyInputPins;
    keyPin    <= keyMeta;
    senseMeta <= {senseIndicatorIn, senseInputA};
    sensePin  <= senseMeta;
  end
end

// ----------------------------------------
// program memory addressing
// ----------------------------------------
// the rom array lives outside; here the address is filtered
wire [9:0] reqAddr = tableFetch ? tablePointer : fetchAddr;
wire       badAddr = (reqAddr >= ROM_WORDS) ||
                     ((reqAddr >= `ROM_TEST_FIRST) && (reqAddr <= `ROM_TEST_LAST));

always @(posedge sys_clk or posedge reset)
begin
  if (reset)
  begin
    romAddr    <= `ROM_RESTART;
    restartReq <= 1'b0;
    fetchWord  <= 10'h000;
  end
  else
  begin
    romAddr    <= badAddr ? `ROM_RESTART : reqAddr;
    restartReq <= badAddr;
    fetchWord  <= romData;
  end
end

// ----------------------------------------
// data memory
// ----------------------------------------
// no reset on the array: pairs 1..15 must survive a reset
reg  [3:0] ramLow  [0:`RAM_PAIRS-1];
reg  [3:0] ramHigh [0:`RAM_PAIRS-1];
reg  [1:0] stackHigh;
reg        resetSeen;
wire [3:0] pairIdx = ramAddr[3:0];
wire       highHalf = ramAddr[4];

always @(posedge sys_clk or posedge reset)
begin
  if (reset)
    resetSeen <= 1'b1;
  else
    resetSeen <= 1'b0;
end

always @(posedge sys_clk)
begin
  if (resetSeen)
  begin
    ramLow[`RAM_PAIR_FIRST]  <= 4'h0;
    ramHigh[`RAM_PAIR_FIRST] <= 4'h0;
  end
  else if (callPush)
  begin
    ramLow[`RAM_PAIR_LAST]  <= returnAddr[3:0];
    ramHigh[`RAM_PAIR_LAST] <= returnAddr[7:4];
  end
  else if (ramPairWrite)
  begin
    ramLow[pairIdx]  <= ramPairData[3:0];
    ramHigh[pairIdx] <= ramPairData[7:4];
  end
  else if (ramWrite)
  begin
    if (highHalf)
      ramHigh[pairIdx] <= accumulator;
    else
      ramLow[pairIdx] <= accumulator;
  end
end

always @(posedge sys_clk or posedge reset)
begin
  if (reset)
    stackHigh <= 2'h0;
  else if (callPush)
    stackHigh <= returnAddr[9:8];
end

// ----------------------------------------
// registered views of memory
// ----------------------------------------
always @(posedge sys_clk or posedge reset)
begin
  if (reset)
  begin
    ramReadPair  <= 8'h00;
    stackTop     <= 10'h000;
    tablePointer <= 10'h000;
  end
  else
  begin
    ramReadPair  <= {ramHigh[pairIdx], ramLow[pairIdx]};
    stackTop     <= {stackHigh, ramHigh[`RAM_PAIR_LAST], ramLow[`RAM_PAIR_LAST]};
    tablePointer <= {controlRegA[`CTRL_A_PTR_HI], controlRegA[`CTRL_A_PTR_LO],
                     ramHigh[`RAM_PAIR_FIRST], ramLow[`RAM_PAIR_FIRST]};
  end
end

// ----------------------------------------
// accumulator and carry
// ----------------------------------------
wire [3:0] ramNibble = highHalf ? ramHigh[pairIdx] : ramLow[pairIdx];
reg  [3:0] next_accumulator;
reg        next_carryBit;

always @*
begin
  next_accumulator = accumulator;
  next_carryBit    = carryBit;
  case (aluOp)
    `OP_AND:
    begin
      next_accumulator = accumulator & operand;
      next_carryBit    = accumulator[3] & operand[3];
    end
    `OP_XOR:
    begin
      next_accumulator = accumulator ^ operand;
      next_carryBit    = accumulator[3] & operand[3];
    end
    `OP_OR:
    begin
      next_accumulator = accumulator | operand;
      next_carryBit    = 1'b0;
    end
    `OP_ROTL:
    begin
      next_accumulator = {accumulator[2:0], accumulator[3]};
      next_carryBit    = accumulator[3];
    end
    `OP_ROTLZ:
    begin
      next_accumulator = {accumulator[2:0], 1'b0};
      next_carryBit    = accumulator[3];
    end
    `OP_INC, `OP_CADJ:
    begin
      next_accumulator = accumulator + 4'h1;
      next_carryBit    = (accumulator == 4'hF);
    end
    `OP_LOAD:
    begin
      next_accumulator = operand;
      next_carryBit    = 1'b0;
    end
    `OP_RAM_READ:
    begin
      next_accumulator = ramNibble;
      next_carryBit    = 1'b0;
    end
    `OP_PORT_IN:
    begin
      next_accumulator = operand[0] ? portReadData[7:4] : portReadData[3:0];
      next_carryBit    = 1'b0;
    end
    default:
    begin
      next_accumulator = accumulator;
      next_carryBit    = carryBit;
    end
  endcase
end

// reset leaves the accumulator alone; only the carry is defined
always @(posedge sys_clk)
begin
  accumulator <= next_accumulator;
end

always @(posedge sys_clk or posedge reset)
begin
  if (reset)
    carryBit <= 1'b0;
  else
    carryBit <= next_carryBit;
end

// ----------------------------------------
// condition bit
// ----------------------------------------
wire keyHigh   = |keyPin;
wire senseHigh = |sensePin;
reg  testHit;

always @*
begin
  testHit = 1'b0;
  case (operand[2:0])
    3'b000, 3'b011, 3'b110: testHit = keyHigh;
    3'b101: testHit = timerZero;
    default: testHit = 1'b0;
  endcase
  if (operand[3] && senseHigh)
    testHit = 1'b1;
end

always @(posedge sys_clk or posedge reset)
begin
  if (reset)
    condBit <= 1'b0;
  else if (standbyExit)
    condBit <= 1'b1;
  else if (condTest)
    condBit <= testHit;
  else if (haltExec && wakeCond)
    condBit <= 1'b1;
  else if (haltExec && condBit)
    condBit <= 1'b0;
end

// ----------------------------------------
// port registers
// ----------------------------------------
reg [7:0] scanLatch;

always @(posedge sys_clk or posedge reset)
begin
  if (reset)
  begin
    scanLatch   <= `SCAN_RESET;
    controlRegA <= `CTRL_A_RESET;
    controlRegB <= `CTRL_B_RESET;
  end
  else if (portWrite)
  begin
    if (portSel == `PORT_SCAN)
      scanLatch <= portWriteData;
    else if (portSel == `PORT_CTRL_A)
      controlRegA <= portWriteData & `CTRL_A_MASK;
    else if (portSel == `PORT_CTRL_B)
      controlRegB <= portWriteData & `CTRL_B_MASK;
  end
end

wire scanOutMode = controlRegB[`CTRL_B_SCAN_OUT];
wire senseOn     = controlRegB[`CTRL_B_SENSE_ON];
wire indOutMode  = controlRegB[`CTRL_B_IND_IN];
reg  [7:0] next_portReadData;

always @*
begin
  next_portReadData = 8'h00;
  if (portSel == `PORT_SCAN)
    next_portReadData = scanOutMode ? scanLatch : scanPin;
  else if (portSel == `PORT_INPUT)
    next_portReadData = {keyPin, sensePin[1], senseOn ? sensePin[0] : 1'b1, 2'b11};
  else if (portSel == `PORT_CTRL_A)
    next_portReadData = controlRegA;
  else
    next_portReadData = controlRegB;
end

// pull-down enables are analog pad controls and stay in controlRegB bits 4/5
always @(posedge sys_clk or posedge reset)
begin
  if (reset)
  begin
    portReadData       <= 8'h00;
    keyScanOut         <= `SCAN_RESET;
    keyScanOe_n        <= 1'b0;
    senseIndicatorOut  <= 1'b1;
    senseIndicatorOe_n <= 1'b0;
  end
  else
  begin
    portReadData       <= next_portReadData;
    keyScanOut         <= scanLatch;
    keyScanOe_n        <= ~scanOutMode;
    senseIndicatorOut  <= 1'b1;
    senseIndicatorOe_n <= ~indOutMode;
  end
end

endmodule

/* tiny_cpu_consts.vh */
// constants for the 4-bit controller datapath, flags and port registers
`ifndef TINY_CPU_CONSTS_VH
`define TINY_CPU_CONSTS_VH
// ----------------------------------------
// program memory
// ----------------------------------------
`define ROM_WIDTH        10
`define ROM_SIZE_DEFAULT 1002
`define ROM_TEST_FIRST   10'h3EA
`define ROM_TEST_LAST    10'h3FF
`define ROM_RESTART      10'h000
// ----------------------------------------
// data memory
// ----------------------------------------
`define RAM_PAIRS        16
`define RAM_PAIR_FIRST   4'h0
`define RAM_PAIR_LAST    4'hF
// ----------------------------------------
// port register selectors
// ----------------------------------------
`define PORT_SCAN        2'h0
`define PORT_INPUT       2'h1
`define PORT_CTRL_A      2'h3
`define PORT_CTRL_B      2'h2
`define SCAN_RESET       8'hFF
`define CTRL_A_RESET     8'h03
`define CTRL_B_RESET     8'h26
`define CTRL_A_MASK      8'h3F
`define CTRL_B_MASK      8'h37
// ----------------------------------------
// field positions
// ----------------------------------------
`define CTRL_A_PTR_LO    4
`define CTRL_A_PTR_HI    5
`define CTRL_B_SENSE_ON  0
`define CTRL_B_SCAN_OUT  1
`define CTRL_B_IND_IN    2
`define CTRL_B_SENSE_PD  4
`define CTRL_B_KEY_PD    5
// ----------------------------------------
// accumulator operations
// ----------------------------------------
`define OP_NONE          4'h0
`define OP_AND           4'h1
`define OP_XOR           4'h2
`define OP_OR            4'h3
`define OP_ROTL          4'h4
`define OP_ROTLZ         4'h5
`define OP_INC           4'h6
`define OP_CADJ          4'h7
`define OP_LOAD          4'h8
`define OP_PORT_IN       4'h9
`define OP_RAM_READ      4'hA
`endif

/* tiny_cpu_datapath_props.sv */
// assertion checker for flags, pointer and port registers of the datapath
`timescale 1ns/1ns
`include "tiny_cpu_consts.vh"
module tiny_cpu_datapath_props
(
  input wire       sys_clk,
  input wire       reset,
  input wire [9:0] fetchAddr,
  input wire       tableFetch,
  input wire [3:0] aluOp,
  input wire [3:0] operand,
  input wire [3:0] accumulator,
  input wire       carryBit,
  input wire       condBit,
  input wire       condTest,
  input wire       haltExec,
  input wire       wakeCond,
  input wire       standbyExit,
  input wire [9:0] romAddr,
  input wire       restartReq,
  input wire       portWrite,
  input wire [1:0] portSel,
  input wire [7:0] portWriteData,
  input wire [7:0] keyScanOut,
  input wire [9:0] tablePointer,
  input wire [7:0] controlRegA,
  input wire [7:0] controlRegB
);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  // halt alone, no higher-priority flag source in the same cycle
  sequence s_halt_only;
    haltExec && !standbyExit && !condTest;
  endsequence
  sequence s_scan_write;
    portWrite && portSel == `PORT_SCAN;
  endsequence
  a_carry_logic: assert property (
    (aluOp == `OP_AND || aluOp == `OP_XOR) |=> carryBit == ($past(accumulator[3]) & $past(operand[3])))
    else $error("carry after and or xor wrong");
  a_carry_rotate: assert property (
    (aluOp == `OP_ROTL || aluOp == `OP_ROTLZ) |=> carryBit == $past(accumulator[3]))
    else $error("carry after rotate wrong");
  a_carry_incr: assert property (
    (aluOp == `OP_INC || aluOp == `OP_CADJ) |=> carryBit == ($past(accumulator) == 4'hF))
    else $error("carry after increment wrong");
  a_carry_cleared: assert property (
    (aluOp == `OP_OR || aluOp == `OP_LOAD || aluOp == `OP_PORT_IN) |=> !carryBit)
    else $error("carry not cleared");
  a_cond_exit: assert property (standbyExit |=> condBit)
    else $error("condition bit not set on standby exit");
  a_halt_wake: assert property (s_halt_only ##0 wakeCond |=> condBit)
    else $error("halt with wake did not set condition bit");
  a_halt_clear: assert property (s_halt_only ##0 (!wakeCond && condBit) |=> !condBit)
    else $error("halt without wake did not clear condition bit");
  a_pointer_top: assert property (tablePointer[9:8] == $past(controlRegA[5:4]))
    else $error("pointer top bits differ from control a");
  a_reserved_zero: assert property (
    controlRegA[7:6] == 2'h0 && controlRegB[7:6] == 2'h0 && !controlRegB[3])
    else $error("reserved control bit set");
  a_test_restart: assert property (
    (!tableFetch && fetchAddr >= `ROM_TEST_FIRST) |=> romAddr == `ROM_RESTART && restartReq)
    else $error("reserved fetch not redirected");
  a_scan_latch: assert property (s_scan_write |-> ##2 keyScanOut == $past(portWriteData, 2))
    else $error("scan output differs from written latch");
endmodule
bind tiny_cpu_datapath tiny_cpu_datapath_props u_tiny_cpu_datapath_props (.*);

/* tiny_cpu_datapath_flags_ports_tb_top.sv */
// self-checking bench for the datapath, flags and port registers
`timescale 1ns/1ns
`include "tiny_cpu_consts.vh"
module tiny_cpu_datapath_flags_ports_tb_top;
  logic       sys_clk, reset, tableFetch, ramWrite, ramPairWrite, callPush;
  logic       condTest, haltExec, wakeCond, standbyExit, timerZero, portWrite, senseInputA, senseIndicatorIn;
  logic [9:0] fetchAddr, romData, returnAddr;
  logic [3:0] aluOp, operand, keyInputPins;
  logic [4:0] ramAddr;
  logic [7:0] ramPairData, portWriteData, keyScanIn;
  logic [1:0] portSel;
  wire  [9:0] romAddr, fetchWord, stackTop, tablePointer;
  wire        restartReq, carryBit, condBit, keyScanOe_n, senseIndicatorOut, senseIndicatorOe_n;
  wire  [7:0] ramReadPair, portReadData, keyScanOut, controlRegA, controlRegB;
  wire  [3:0] accumulator;
  int         failures;
  int         num_checks;
  tiny_cpu_datapath u_tiny_cpu_datapath (.*);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task finish_test;
    if (failures == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input [9:0] got, input [9:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task pw(input [1:0] s, input [7:0] d);
    @(posedge sys_clk)
    begin
      portWrite <= 1'h1;
      portSel <= s;
      portWriteData <= d;
    end
    @(posedge sys_clk) portWrite <= 1'h0;
  endtask
  // two edges so the latch and the read register have both settled
  task pr(input [1:0] s, input [7:0] e);
    @(posedge sys_clk) portSel <= s;
    tick(2);
    #1 chk(portReadData, e);
  endtask
  task op1(input [3:0] op, input [3:0] b, input c);
    @(posedge sys_clk)
    begin
      aluOp <= op;
      operand <= b;
    end
    @(posedge sys_clk) aluOp <= `OP_NONE;
    @(posedge sys_clk) #1 chk(carryBit, c);
  endtask
  task alu(input [3:0] op, input [3:0] a, input [3:0] b, input c);
    op1(`OP_LOAD, a, 1'h0);
    op1(op, b, c);
  endtask
  // k: 0 status test, 1 halt, 2 standby exit
  task fl(input [1:0] k, input [3:0] b, input e);
    @(posedge sys_clk)
    begin
      operand <= b;
      condTest <= k == 2'h0;
      haltExec <= k == 2'h1;
      standbyExit <= k == 2'h2;
    end
    @(posedge sys_clk) {condTest, haltExec, standbyExit} <= 3'h0;
    @(posedge sys_clk) #1 chk(condBit, e);
  endtask
  // pins pass a two-flop synchroniser first
  task pins(input [3:0] k, input s);
    @(posedge sys_clk)
    begin
      keyInputPins <= k;
      senseInputA <= s;
    end
    tick(3);
  endtask
  // ----------------------------------------
  // stimulus
  // ----------------------------------------
  initial
  begin
    sys_clk = 1'h0;
    forever #5 sys_clk = ~sys_clk;
  end
  initial
  begin
    tick(20000);
    failures++;
    finish_test;
  end
  initial
  begin
    {tableFetch, ramWrite, ramPairWrite, callPush, condTest, haltExec, wakeCond} = 7'h0;
    {standbyExit, timerZero, portWrite, senseInputA, senseIndicatorIn} = 5'h0;
    {fetchAddr, romData, returnAddr} = 30'h0;
    {aluOp, operand, ramAddr, ramPairData, portWriteData, portSel} = 35'h0;
    keyInputPins = 4'hA;
    keyScanIn = 8'h3C;
    reset = 1'h1;
    tick(3);
    reset <= 1'h0;
    tick(2);
    #1 chk(controlRegA, 8'h03);
    chk(controlRegB, 8'h26);
    chk(keyScanOut, 8'hFF);
    chk(tablePointer, 10'h000);
    chk(ramReadPair, 8'h00);
    chk(senseIndicatorOe_n, 1'h0);
    chk(senseIndicatorOut, 1'h1);
    pr(`PORT_SCAN, 8'hFF);
    pr(`PORT_INPUT, 8'hA7);
    pw(`PORT_CTRL_A, 8'hF5);
    pr(`PORT_CTRL_A, 8'h35);
    pw(`PORT_CTRL_B, 8'hFF);
    pr(`PORT_CTRL_B, 8'h37);
    pr(`PORT_INPUT, 8'hA3);
    pw(`PORT_CTRL_B, 8'h31);
    pw(`PORT_SCAN, 8'h55);
    pr(`PORT_SCAN, 8'h3C);
    chk(keyScanOut, 8'h55);
    chk(keyScanOe_n, 1'h1);
    chk(senseIndicatorOe_n, 1'h1);
    pw(`PORT_CTRL_B, 8'h37);
    pr(`PORT_SCAN, 8'h55);
    chk(senseIndicatorOe_n, 1'h0);
    @(posedge sys_clk)
    begin
      ramPairWrite <= 1'h1;
      ramPairData <= 8'hEA;
    end
    @(posedge sys_clk) ramPairWrite <= 1'h0;
    tick(2);
    #1 chk(tablePointer, 10'h3EA);
    chk(ramReadPair, 8'hEA);
    @(posedge sys_clk) tableFetch <= 1'h1;
    tick(2);
    #1 chk(romAddr, 10'h000);
    @(posedge sys_clk)
    begin
      tableFetch <= 1'h0;
      fetchAddr <= 10'h123;
      romData <= 10'h2B7;
    end
    tick(2);
    #1 chk(romAddr, 10'h123);
    chk(fetchWord, 10'h2B7);
    chk(restartReq, 1'h0);
    @(posedge sys_clk) fetchAddr <= 10'h3FF;
    tick(2);
    #1 chk(romAddr, 10'h000);
    chk(restartReq, 1'h1);
    @(posedge sys_clk)
    begin
      callPush <= 1'h1;
      returnAddr <= 10'h2C5;
      ramAddr <= 5'h0F;
    end
    @(posedge sys_clk) callPush <= 1'h0;
    tick(2);
    #1 chk(stackTop, 10'h2C5);
    chk(ramReadPair, 8'hC5);
    alu(`OP_CADJ, 4'h0, 4'h0, 1'h0);
    alu(`OP_INC, 4'hE, 4'h0, 1'h0);
    alu(`OP_CADJ, 4'hF, 4'h0, 1'h1);
    alu(`OP_INC, 4'hF, 4'h0, 1'h1);
    chk(accumulator, 4'h0);
    alu(`OP_AND, 4'h8, 4'h8, 1'h1);
    alu(`OP_AND, 4'h8, 4'h7, 1'h0);
    alu(`OP_XOR, 4'h8, 4'h8, 1'h1);
    alu(`OP_XOR, 4'h7, 4'hF, 1'h0);
    alu(`OP_ROTL, 4'h8, 4'h0, 1'h1);
    op1(`OP_OR, 4'h3, 1'h0);
    alu(`OP_ROTL, 4'h7, 4'h0, 1'h0);
    alu(`OP_ROTLZ, 4'h9, 4'h0, 1'h1);
    op1(`OP_PORT_IN, 4'h0, 1'h0);
    op1(`OP_LOAD, 4'h9, 1'h0);
    @(posedge sys_clk)
    begin
      ramWrite <= 1'h1;
      ramAddr <= 5'h13;
    end
    @(posedge sys_clk) ramWrite <= 1'h0;
    op1(`OP_LOAD, 4'h2, 1'h0);
    op1(`OP_RAM_READ, 4'h0, 1'h0);
    chk(accumulator, 4'h9);
    @(posedge sys_clk) ramAddr <= 5'h0F;
    for (int i = 0; i < 3; i++)
    begin
      pins(4'h2, 1'h0);
      fl(2'h0, 4'h6 >> (i * 2) & 4'h7 | (i == 1 ? 4'h3 : 4'h0), 1'h1);
      pins(4'h0, 1'h0);
      fl(2'h0, i == 0 ? 4'h0 : (i == 1 ? 4'h3 : 4'h6), 1'h0);
    end
    @(posedge sys_clk) timerZero <= 1'h1;
    fl(2'h0, 4'h5, 1'h1);
    @(posedge sys_clk) timerZero <= 1'h0;
    fl(2'h0, 4'h5, 1'h0);
    pins(4'h0, 1'h1);
    fl(2'h0, 4'h8, 1'h1);
    pins(4'h0, 1'h0);
    fl(2'h0, 4'h8, 1'h0);
    fl(2'h2, 4'h0, 1'h1);
    fl(2'h1, 4'h0, 1'h0);
    @(posedge sys_clk) wakeCond <= 1'h1;
    fl(2'h1, 4'h0, 1'h1);
    @(posedge sys_clk) reset <= 1'h1;
    tick(2);
    reset <= 1'h0;
    tick(2);
    #1 chk(tablePointer, 10'h000);
    chk(controlRegA, 8'h03);
    chk(ramReadPair, 8'hC5);
    finish_test;
  end
endmodule
